// [rtl/flash_status_regs.svh]
// constants of the status byte and write-enable latch logic
`ifndef FLASH_STATUS_REGS_SVH
`define FLASH_STATUS_REGS_SVH

// status byte reset value and field positions
`define STATUS_RESET      8'h00
`define BUSY_BIT          0
`define LATCH_BIT         1
`define PROTECT_LSB       2
`define PROTECT_MSB       5
`define QUAD_BIT          6
`define LOCK_BIT          7

// serial frame bit counts (posedge count after which a byte is complete)
`define OPCODE_LAST       5'h07
`define OPCODE_DONE       5'h08
`define DATA_LAST         5'h0F
`define FRAME_SAT         5'h10

// internal write cycle length: time in ns, clock period in ns
`define OP_TIME_NS        10000
`define CLK_PERIOD_NS     10
`define OP_COUNT_W        20

// single opcodes
`define OP_SET_LATCH      8'h06
`define OP_CLEAR_LATCH    8'h04
`define OP_READ_STATUS    8'h05
`define OP_STATUS_WRITE   8'h01
`define OP_CHIP_ERASE_A   8'hC7
`define OP_CHIP_ERASE_B   8'h60
`define OP_SUSPEND        8'h75
`define OP_RESUME         8'h7A
`define OP_RESET_ENABLE   8'h66
`define OP_SOFT_RESET     8'h99

// opcode groups needing the write latch
`define OPS_ARRAY         8'h02, 8'h12, 8'h32, 8'h34, 8'h38, 8'h3E, 8'hD7, 8'h20, 8'h21, 8'h52, 8'h5C, \
                          8'hD8, 8'hDC, 8'h64, 8'h62
`define OPS_NV_REG        8'h42, 8'h65, 8'h85, 8'h18, 8'hFD, 8'hE3, 8'hE4, 8'h2F, 8'hA6, 8'h91, 8'h7E, \
                          8'h98, 8'hE8, 8'h43
`define OPS_VOL_REG       8'h63, 8'h83, 8'hC5, 8'hFB, 8'hE1, 8'h4A

`endif

// [rtl/flash_status_pkg.sv]
// types of the status byte and write-enable latch logic
`include "flash_status_regs.svh"
package flash_status_pkg;

    // status byte, bit 7 down to bit 0
    typedef struct packed {
        logic       status_lock;
        logic       quad_lines_on;
        logic [3:0] protect_code;
        logic       write_latch;
        logic       busy_flag;
    } status_type;

    typedef enum logic [1:0] {idle, running, suspended} op_state_type;

    typedef enum logic [1:0] {no_write, array_write, nv_reg_write, vol_reg_write} op_kind_type;

    // command captured on the serial clock, read by the system side after the frame
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] data;
        logic       data_full;
        logic       toggle;
    } cmd_type;

    typedef struct packed {
        logic [4:0] bit_count;
        logic [7:0] shift;
    } frame_type;

    typedef struct packed {
        logic [7:0] out_shift;
        logic       out_on;
    } drive_type;

    typedef struct packed {
        logic                   cs_meta;
        logic                   cs_sync;
        logic                   cs_prev;
        logic                   tog_meta;
        logic                   tog_sync;
        logic                   tog_seen;
        logic                   wp_meta;
        logic                   wp_sync;
        status_type             status;
        logic [7:0]             shadow;
        op_state_type           op_state;
        logic                   suspendable;
        logic                   reset_armed;
        logic [`OP_COUNT_W-1:0] op_count;
    } core_type;

endpackage

// [rtl/flash_status_write_enable.sv]
// status byte, write-enable latch and busy tracking of a serial flash
// Summary of operation
// - continued register reads repeat the same byte until chip select rises
// - status bit 0 is the read-only busy flag
// - status bit 1 shows the volatile write latch
// - status bits 2 to 5 hold the four-bit block protection code
// - status bit 6 is the writable quad-enable bit
// - status bit 7 is the writable status-write-disable bit
// - status write changes bits 2 to 7 only, never the write latch
// - writable status bits start at zero, whole byte zero by default
// - busy flag stays set throughout every program, erase or non-volatile register write, except while suspended or after a soft reset
// - while busy only status reads, suspend and resets are obeyed
// - suspend is obeyed during a program or erase operation
// - busy clears at the end of an operation, new commands then accepted
// - write-class commands are inhibited while the write latch is clear
// - opcode 06h sets the write latch; host sends it before writes
// - write-disable command clears the write latch
// - write latch clears itself when a program, erase or non-volatile register write completes
// - page program opcodes need the write latch set first
// - sector, block and chip erase opcodes need the write latch set first
// - register write opcodes need the write latch set first
// - sector protection opcodes need the write latch set first
// - info row, bank register and learning pattern writes need the latch
// - lock bit with write-protect pin low makes status write ignored unless quad-enable is set
// - chip erase ignored unless the protection code is zero
// - quad-enable turns the write-protect and hold pins into data lines
`timescale 1ns/1ns
`include "flash_status_regs.svh"

module flash_status_write_enable #(
    parameter int unsigned OP_CYCLES = `OP_TIME_NS / `CLK_PERIOD_NS
) (
    input  wire logic clk_sys,
    input  wire logic rst_b,
    input  wire logic sck,
    input  wire logic cs_b,
    input  wire logic si,
    input  wire logic wp_b,
    output logic      so,
    output logic      so_oe,
    output logic      quad_lines_on
);

    ////////////////////////////////////////////////////////////////////////////
    // opcode classification

    // the group decides busy behaviour: array work may be suspended
    function automatic flash_status_pkg::op_kind_type kind_of(input logic [7:0] op);
        case (op)
            `OPS_ARRAY, `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B: kind_of = flash_status_pkg::array_write;
            `OPS_NV_REG, `OP_STATUS_WRITE:                  kind_of = flash_status_pkg::nv_reg_write;
            `OPS_VOL_REG:                                   kind_of = flash_status_pkg::vol_reg_write;
            default:                                        kind_of = flash_status_pkg::no_write;
        endcase
    endfunction

    localparam logic [`OP_COUNT_W-1:0] OP_LAST = `OP_COUNT_W'(OP_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////
    // link side, clocked by the host serial clock

    flash_status_pkg::frame_type frame;
    flash_status_pkg::frame_type next_frame;
    flash_status_pkg::cmd_type   cmd;
    flash_status_pkg::cmd_type   next_cmd;
    flash_status_pkg::drive_type drive;
    flash_status_pkg::drive_type next_drive;
    flash_status_pkg::core_type  core;
    flash_status_pkg::core_type  next_core;
    logic                        frame_rst_b;

    // frame state dies with chip select, so a stopped clock leaves nothing behind
    assign frame_rst_b = rst_b & ~cs_b;

    // shift in opcode and one data byte; the command survives the frame end
    always_comb begin
        next_frame = frame;
        next_cmd = cmd;
        next_frame.shift = {frame.shift[6:0], si};
        if (frame.bit_count != `FRAME_SAT) begin
            next_frame.bit_count = frame.bit_count + 5'h01;
        end
        if (frame.bit_count == `OPCODE_LAST) begin
            next_cmd.opcode = {frame.shift[6:0], si};
            next_cmd.toggle = ~cmd.toggle;
            next_cmd.data_full = 1'b0;
        end
        if (frame.bit_count == `DATA_LAST) begin
            next_cmd.data = {frame.shift[6:0], si};
            next_cmd.data_full = 1'b1;
        end
    end

    always_ff @(posedge sck or negedge frame_rst_b) begin
        if (!frame_rst_b) begin
            frame <= '0;
        end else begin
            frame <= next_frame;
        end
    end

    // toggle marks a new opcode for the system side
    always_ff @(posedge sck or negedge rst_b) begin
        if (!rst_b) begin
            cmd <= '0;
        end else begin
            cmd <= next_cmd;
        end
    end

    // status read: load the frozen snapshot, then rotate so the byte repeats
    always_comb begin
        next_drive = drive;
        if (drive.out_on) begin
            next_drive.out_shift = {drive.out_shift[6:0], drive.out_shift[7]};
        end else if (frame.bit_count == `OPCODE_DONE && cmd.opcode == `OP_READ_STATUS) begin
            next_drive.out_shift = core.shadow;
            next_drive.out_on = 1'b1;
        end
    end

    // falling edge drive keeps data steady around the host's rising sample edge
    always_ff @(negedge sck or negedge frame_rst_b) begin
        if (!frame_rst_b) begin
            drive <= '0;
        end else begin
            drive <= next_drive;
        end
    end

    assign so = drive.out_shift[7];
    assign so_oe = drive.out_on;

    ////////////////////////////////////////////////////////////////////////////
    // system side: command execution, status byte and busy timer

    logic                         cs_rise;
    logic                         exec;
    logic [7:0]                   op;
    flash_status_pkg::op_kind_type kind;
    logic                         locked;
    logic                         busy;

    // opcode and data are only read after the toggle handshake says they are settled
    assign cs_rise = core.cs_sync & ~core.cs_prev;
    assign exec = cs_rise & (core.tog_sync != core.tog_seen);
    assign op = cmd.opcode;
    assign kind = kind_of(cmd.opcode);
    // quad mode takes the protect pin away, so its lock cannot apply
    assign locked = core.status.status_lock & ~core.wp_sync & ~core.status.quad_lines_on;
    assign busy = core.op_state == flash_status_pkg::running;

    always_comb begin
        next_core = core;
        next_core.cs_meta = cs_b;
        next_core.cs_sync = core.cs_meta;
        next_core.cs_prev = core.cs_sync;
        next_core.tog_meta = cmd.toggle;
        next_core.tog_sync = core.tog_meta;
        next_core.wp_meta = wp_b;
        next_core.wp_sync = core.wp_meta;
        if (cs_rise) begin
            next_core.tog_seen = core.tog_sync;
        end
        // snapshot only changes outside frames, so the link sees a stable byte
        if (core.cs_sync) begin
            next_core.shadow = core.status;
        end
        // internal write cycle timer
        if (busy) begin
            if (core.op_count == '0) begin
                next_core.op_state = flash_status_pkg::idle;
                next_core.status.write_latch = 1'b0;
            end else begin
                next_core.op_count = core.op_count - `OP_COUNT_W'(1);
            end
        end
        if (exec) begin
            next_core.reset_armed = (op == `OP_RESET_ENABLE);
            if (op == `OP_SOFT_RESET && core.reset_armed) begin
                // reset is obeyed even while busy and abandons the operation
                next_core.op_state = flash_status_pkg::idle;
                next_core.status.write_latch = 1'b0;
            end else if (busy) begin
                if (op == `OP_SUSPEND && core.suspendable) begin
                    next_core.op_state = flash_status_pkg::suspended;
                end
            end else if (core.op_state == flash_status_pkg::suspended) begin
                if (op == `OP_RESUME) begin
                    next_core.op_state = flash_status_pkg::running;
                end
            end else if (op == `OP_SET_LATCH) begin
                next_core.status.write_latch = 1'b1;
            end else if (op == `OP_CLEAR_LATCH) begin
                next_core.status.write_latch = 1'b0;
            end else if (kind != flash_status_pkg::no_write && core.status.write_latch) begin
                if (op == `OP_STATUS_WRITE) begin
                    // latch bit is left alone; it clears only when the cycle ends
                    if (cmd.data_full && !locked) begin
                        next_core.status.status_lock = cmd.data[`LOCK_BIT];
                        next_core.status.quad_lines_on = cmd.data[`QUAD_BIT];
                        next_core.status.protect_code = cmd.data[`PROTECT_MSB:`PROTECT_LSB];
                        next_core.op_state = flash_status_pkg::running;
                        next_core.suspendable = 1'b0;
                        next_core.op_count = OP_LAST;
                    end
                end else if ((op == `OP_CHIP_ERASE_A || op == `OP_CHIP_ERASE_B)
                             && core.status.protect_code != 4'h0) begin
                    next_core.op_state = core.op_state;
                end else if (kind != flash_status_pkg::vol_reg_write) begin
                    next_core.op_state = flash_status_pkg::running;
                    next_core.suspendable = (kind == flash_status_pkg::array_write);
                    next_core.op_count = OP_LAST;
                end
            end
        end
        next_core.status.busy_flag = (next_core.op_state == flash_status_pkg::running);
    end

    // writable bits come up as shipped, all zero
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            core <= '{cs_meta: 1'b1, cs_sync: 1'b1, cs_prev: 1'b1, tog_meta: 1'b0, tog_sync: 1'b0,
                      tog_seen: 1'b0, wp_meta: 1'b1, wp_sync: 1'b1,
                      status: flash_status_pkg::status_type'(`STATUS_RESET),
                      shadow: `STATUS_RESET, op_state: flash_status_pkg::idle, suspendable: 1'b0,
                      reset_armed: 1'b0, op_count: '0};
        end else begin
            core <= next_core;
        end
    end

    assign quad_lines_on = core.status.quad_lines_on;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    sequence op_begins;
        $rose(core.status.busy_flag);
    endsequence

    sequence op_ends;
        $fell(core.status.busy_flag) && core.op_state == flash_status_pkg::idle;
    endsequence

    sequence latch_cmd(logic [7:0] code);
        exec && !busy && core.op_state == flash_status_pkg::idle && op == code;
    endsequence

    sequence status_write_ok;
        latch_cmd(`OP_STATUS_WRITE) ##0 (core.status.write_latch && cmd.data_full && !locked);
    endsequence

    // only a taken command may raise busy, so the link cannot write it
    busy_bit_map_a: assert property (!core.status.busy_flag && !exec |=> !core.status.busy_flag)
        else $error("busy rose without a command");

    busy_holds_a: assert property (op_begins |-> core.status.busy_flag [*8])
        else $error("busy flag dropped early");

    latch_set_a: assert property (latch_cmd(`OP_SET_LATCH) |=> core.status.write_latch)
        else $error("set latch command did not set the latch");

    latch_clear_a: assert property (latch_cmd(`OP_CLEAR_LATCH) |=> !core.status.write_latch)
        else $error("clear latch command did not clear the latch");

    latch_auto_clear_a: assert property (op_ends |-> !core.status.write_latch)
        else $error("latch still set after operation end");

    status_write_latch_a: assert property (latch_cmd(`OP_STATUS_WRITE) ##0 core.status.write_latch
                                           |=> core.status.write_latch)
        else $error("status write touched the latch");

    // the last timer cycle clears the latch on its own, so it is left out here
    busy_ignores_a: assert property (exec && busy && core.op_count != '0
                                     && (op == `OP_SET_LATCH || op == `OP_CLEAR_LATCH)
                                     |=> $stable(core.status.write_latch))
        else $error("command obeyed while busy");

    inhibit_write_a: assert property (exec && core.op_state == flash_status_pkg::idle
                                      && !core.status.write_latch && kind != flash_status_pkg::no_write
                                      |=> core.op_state == flash_status_pkg::idle)
        else $error("write started with latch clear");

    lock_holds_a: assert property (exec && locked && op == `OP_STATUS_WRITE
                                   |=> $stable(core.status[7:2]))
        else $error("locked status byte changed");

    chip_erase_guard_a: assert property (exec && !busy && (op == `OP_CHIP_ERASE_A || op == `OP_CHIP_ERASE_B)
                                         && core.status.protect_code != 4'h0
                                         |=> !core.status.busy_flag)
        else $error("chip erase ran with protection set");

    suspend_obeyed_a: assert property (exec && busy && core.suspendable && op == `OP_SUSPEND
                                       |=> core.op_state == flash_status_pkg::suspended ##0 !core.status.busy_flag)
        else $error("suspend not obeyed during array operation");

    quad_pins_a: assert property (quad_lines_on == core.status.quad_lines_on)
        else $error("quad pin mode does not follow the status bit");

    ////////////////////////////////////////////////////////////////////////////
    // writable bits and the latch each have exactly one way in

    // protect, quad and lock bits never move between commands
    nv_bits_hold_a: assert property (!exec |=> $stable(core.status[7:2]))
        else $error("writable status bits moved");

    status_write_takes_a: assert property (status_write_ok |=> core.status[7:2] == $past(cmd.data[7:2]))
        else $error("status write lost its data");

    status_write_busy_a: assert property (status_write_ok |=> core.status.busy_flag)
        else $error("status write did not start");

    latch_set_only_a: assert property ($rose(core.status.write_latch)
                                       |-> $past(exec) && $past(op) == `OP_SET_LATCH)
        else $error("latch rose without set command");

    // timer: full count on a fresh start, holds busy, lets go at zero
    timer_load_a: assert property (exec && core.op_state == flash_status_pkg::idle
                                   ##1 $rose(core.status.busy_flag) |-> core.op_count == OP_LAST)
        else $error("cycle started short");

    busy_stays_a: assert property (busy && core.op_count != '0 && !exec |=> core.status.busy_flag)
        else $error("busy dropped early");

    busy_ends_a: assert property (busy && core.op_count == '0 |=> !core.status.busy_flag)
        else $error("busy outlived the timer");

    // a suspended operation answers only resume and the reset pair
    suspend_ignores_a: assert property (exec && core.op_state == flash_status_pkg::suspended
                                        && op != `OP_RESUME && op != `OP_SOFT_RESET |=> $stable(core.status))
        else $error("command obeyed while suspended");

    resume_runs_a: assert property (exec && core.op_state == flash_status_pkg::suspended
                                    && op == `OP_RESUME |=> core.status.busy_flag)
        else $error("resume did not restart");

    soft_reset_a: assert property (exec && op == `OP_SOFT_RESET && core.reset_armed
                                   |=> !core.status.write_latch && !core.status.busy_flag)
        else $error("soft reset ignored");

    vol_write_quiet_a: assert property (exec && core.op_state == flash_status_pkg::idle
                                        && kind == flash_status_pkg::vol_reg_write |=> !core.status.busy_flag)
        else $error("volatile write set busy");

    erase_runs_a: assert property (latch_cmd(`OP_CHIP_ERASE_A)
                                   ##0 (core.status.write_latch && core.status.protect_code == 4'h0)
                                   |=> core.status.busy_flag)
        else $error("free chip erase did not start");

    // the link reads the snapshot on its own clock, so it must sit still
    snapshot_frozen_a: assert property (!core.cs_sync |=> $stable(core.shadow))
        else $error("snapshot moved while selected");

    ////////////////////////////////////////////////////////////////////////////
    // link checks on the serial clock; deselect clears the drive state

    byte_load_a: assert property (@(negedge sck) drive.out_on && !$past(drive.out_on)
                                  |-> drive.out_shift == core.shadow)
        else $error("read did not load the snapshot");

    byte_repeat_a: assert property (@(negedge sck) drive.out_on && $past(drive.out_on)
                                    |-> drive.out_shift == {$past(drive.out_shift[6:0]), $past(drive.out_shift[7])})
        else $error("byte not rotated for repeat");

    oe_read_only_a: assert property (@(negedge sck) drive.out_on |-> cmd.opcode == `OP_READ_STATUS)
        else $error("output driven outside a read");

endmodule

// [testbench/spi_host_model.sv]
// host-side serial controller model that frames commands and reads status
`timescale 1ns/1ns
module spi_host_model (
    output logic      sck,
    output logic      cs_b,
    output logic      si,
    input  wire logic so,
    input  wire logic so_oe
);
    localparam int HALF = 15;

    // serial clock parked low outside frames, select idle high
    initial begin
        sck  = 1'b0;
        cs_b = 1'b1;
        si   = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one 24-clock frame: opcode, data byte, spare byte; two bytes read back
    task automatic frame(input logic [7:0] op, input logic [7:0] dat, output logic [7:0] rd_a,
                         output logic [7:0] rd_b, output logic oe_all);
        logic [23:0] tx;
        logic [15:0] rx;
        tx     = {op, dat, 8'h00};
        rx     = 16'h0000;
        oe_all = 1'b1;
        #7 cs_b = 1'b0;
        #45; // select setup, lets the device freeze its snapshot first
        for (int i = 23; i >= 0; i--) begin
            si = tx[i]; // msb first, changed on the falling edge
            #HALF sck = 1'b1;
            if (i < 16) begin
                rx     = {rx[14:0], so};
                oe_all = oe_all & so_oe;
            end
            #HALF sck = 1'b0;
        end
        #HALF cs_b = 1'b1;
        si = ~si; // released line must not keep a stale value
        #60; // deselect gap between frames
        rd_a = rx[15:8];
        rd_b = rx[7:0];
    endtask
endmodule

// [testbench/tb.sv]
// self-checking bench for the status byte and write-enable latch block
`timescale 1ns/1ns
`include "flash_status_regs.svh"
module tb;
    localparam int unsigned OP_CYCLES = 150; // shortened write cycle
    localparam logic [7:0] OPS_BUSY [31] = '{8'h02, 8'h12, 8'h32, 8'h34, 8'h38, 8'h3E, 8'hD7, 8'h20,
        8'h21, 8'h52, 8'h5C, 8'hD8, 8'hDC, 8'hC7, 8'h60, 8'h42, 8'h65, 8'h85, 8'h64, 8'h62, 8'h18,
        8'hFD, 8'hE3, 8'hE4, 8'h2F, 8'hA6, 8'h91, 8'h7E, 8'h98, 8'hE8, 8'h43};
    localparam logic [7:0] OPS_VOL [6] = '{8'h63, 8'h83, 8'hC5, 8'hFB, 8'hE1, 8'h4A};
    logic clk_sys     = 1'b0;
    logic rst_b       = 1'b0;
    logic wp_b        = 1'b1;
    logic sck;
    logic cs_b;
    logic si;
    logic so;
    logic so_oe;
    logic quad_lines_on;
    int   n_fail      = 0;
    int   comparisons = 0;

    spi_host_model host (.sck(sck), .cs_b(cs_b), .si(si), .so(so), .so_oe(so_oe));

    flash_status_write_enable #(.OP_CYCLES(OP_CYCLES)) uut (
        .clk_sys(clk_sys), .rst_b(rst_b), .sck(sck), .cs_b(cs_b), .si(si),
        .wp_b(wp_b), .so(so), .so_oe(so_oe), .quad_lines_on(quad_lines_on));

    // 100 MHz system clock
    always #5 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cmd(input logic [7:0] op, input logic [7:0] dat);
        logic [7:0] a;
        logic [7:0] b;
        logic       oe;
        @(negedge clk_sys);
        host.frame(op, dat, a, b, oe);
    endtask

    // status read: byte twice in one frame, enable only while selected
    task automatic rd_status(input logic [7:0] exp);
        logic [7:0] a;
        logic [7:0] b;
        logic       oe;
        @(negedge clk_sys);
        host.frame(`OP_READ_STATUS, 8'h00, a, b, oe);
        chk(a, exp, "status byte");
        chk(b, exp, "repeated status byte");
        chk({7'h00, oe}, 8'h01, "output enable in frame");
        chk({7'h00, so_oe}, 8'h00, "output enable after deselect");
    endtask

    // poll until ready, bounded; a hang shows as a busy final byte
    task automatic wait_ready(input logic [7:0] exp);
        logic [7:0] a;
        logic [7:0] b;
        logic       oe;
        a = 8'h01;
        for (int i = 0; i < 40 && a[`BUSY_BIT] !== 1'b0; i++) begin
            @(negedge clk_sys);
            host.frame(`OP_READ_STATUS, 8'h00, a, b, oe);
        end
        chk(a, exp, "status after operation");
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic test_reset;
        chk({7'h00, quad_lines_on}, 8'h00, "quad after reset");
        rd_status(`STATUS_RESET);
        $display("test reset done");
    endtask

    task automatic test_latch;
        cmd(`OP_SET_LATCH, 8'h00);
        rd_status(8'h02);
        cmd(`OP_CLEAR_LATCH, 8'h00);
        rd_status(8'h00);
        $display("test latch done");
    endtask

    // every busy-raising opcode but status write: refused without latch, runs with it; volatile writes tried with latch only
    task automatic test_ops;
        foreach (OPS_BUSY[i]) begin
            cmd(OPS_BUSY[i], 8'h00);
            rd_status(8'h00);
            cmd(`OP_SET_LATCH, 8'h00);
            cmd(OPS_BUSY[i], 8'h00);
            rd_status(8'h03);
            wait_ready(8'h00);
        end
        foreach (OPS_VOL[i]) begin
            cmd(`OP_SET_LATCH, 8'h00);
            cmd(OPS_VOL[i], 8'h00);
            rd_status(8'h02);
            cmd(`OP_CLEAR_LATCH, 8'h00);
        end
        $display("test opcodes done");
    endtask

    // suspend and resume a program, then soft reset out of a suspend
    task automatic test_suspend;
        cmd(`OP_SET_LATCH, 8'h00);
        cmd(8'h02, 8'h00);
        cmd(`OP_SUSPEND, 8'h00);
        rd_status(8'h02);
        cmd(`OP_RESUME, 8'h00);
        rd_status(8'h03);
        wait_ready(8'h00);
        cmd(`OP_SET_LATCH, 8'h00);
        cmd(8'h02, 8'h00);
        cmd(`OP_SUSPEND, 8'h00);
        cmd(`OP_RESET_ENABLE, 8'h00);
        cmd(`OP_SOFT_RESET, 8'h00);
        rd_status(8'h00);
        $display("test suspend done");
    endtask

    // low data bits must not reach busy or latch; write-disable ignored while busy
    task automatic test_status_write;
        cmd(`OP_SET_LATCH, 8'h00);
        cmd(`OP_STATUS_WRITE, 8'h7D);
        cmd(`OP_CLEAR_LATCH, 8'h00);
        rd_status(8'h7F);
        wait_ready(8'h7C);
        chk({7'h00, quad_lines_on}, 8'h01, "quad lines on");
        $display("test status write done");
    endtask

    task automatic test_chip_erase;
        cmd(`OP_SET_LATCH, 8'h00);
        cmd(`OP_CHIP_ERASE_A, 8'h00);
        rd_status(8'h7E);
        cmd(`OP_CLEAR_LATCH, 8'h00);
        rd_status(8'h7C);
        $display("test chip erase done");
    endtask

    task automatic test_lock;
        cmd(`OP_SET_LATCH, 8'h00);
        cmd(`OP_STATUS_WRITE, 8'h80);
        wait_ready(8'h80);
        @(negedge clk_sys) wp_b = 1'b0;
        cmd(`OP_SET_LATCH, 8'h00);
        cmd(`OP_STATUS_WRITE, 8'h00);
        rd_status(8'h82);
        @(negedge clk_sys) wp_b = 1'b1;
        cmd(`OP_STATUS_WRITE, 8'h00);
        rd_status(8'h03);
        wait_ready(8'h00);
        chk({7'h00, quad_lines_on}, 8'h00, "quad lines off");
        $display("test lock done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys) rst_b = 1'b1;
        repeat (4) @(negedge clk_sys);
        test_reset();
        test_latch();
        test_ops();
        test_suspend();
        test_status_write();
        test_chip_erase();
        test_lock();
        end_sim();
    end

    // watchdog: normal run is about a quarter of this span
    initial begin
        #1000000;
        n_fail++;
        $display("Error at %0t: watchdog expired", $time);
        end_sim();
    end
endmodule
